// ---- hdl/swf_pkg.sv ----
// constants and types shared by the wake, fail-safe and pin control block
package swf_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SUPPLY = 8'h0C;
	localparam logic [7:0] ADDR_HOLD   = 8'h0E;
	localparam logic [7:0] ADDR_CAN    = 8'h10;
	localparam logic [7:0] ADDR_LOCAL_WAKE_IN_A  = 8'h11;
	localparam logic [7:0] ADDR_LOCAL_WAKE_IN_B  = 8'h12;
	localparam logic [7:0] ADDR_DEVCFG = 8'h1A;
	localparam logic [7:0] ADDR_LIN    = 8'h1D;
	localparam logic [7:0] ADDR_FLAG   = 8'h29;
	localparam logic [7:0] ADDR_LOCAL_WAKE_IN_C  = 8'h2A;
	localparam logic [7:0] ADDR_WAKE4  = 8'h2B;
	localparam logic [7:0] ADDR_RATE   = 8'h44;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int XCVR_EN_BIT     = 0;
	localparam int XCVR_FOLLOW_BIT = 1;
	localparam int HOLD_POL_BIT    = 0;
	localparam int HOLD_WAKE_BIT   = 1;
	localparam int LIMP_FS_BIT     = 0;
	localparam int LIMP_STATE_BIT  = 5;
	localparam int LIMP_RD_EN_BIT  = 6;
	localparam int FLAG_LEVEL_BIT  = 4;
	localparam int FLAG_RSTMON_BIT = 5;
	localparam int CYCLIC_BIT      = 0;
	localparam int DIRECT_BIT      = 1;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_SUPPLY = 8'h00;
	localparam logic [7:0] RST_HOLD   = 8'h01;
	localparam logic [7:0] RST_CAN    = 8'h00;
	localparam logic [2:0] RST_WAKEEN = 3'h7;
	localparam logic [7:0] RST_DEVCFG = 8'h00;
	localparam logic [7:0] RST_LIN    = 8'h00;
	localparam logic [7:0] RST_FLAG   = 8'h20;
	localparam logic [7:0] RST_LOCAL_WAKE_IN_C  = 8'h00;
	localparam logic [7:0] RST_WAKE4  = 8'h00;
	localparam logic [7:0] RST_RATE   = 8'h00;
	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] WMODE_BOTH  = 2'h0;
	localparam logic [1:0] WMODE_RISE  = 2'h1;
	localparam logic [1:0] WMODE_FALL  = 2'h2;
	localparam logic [1:0] WMODE_PULSE = 2'h3;
	localparam logic [2:0] MODE_NORMAL   = 3'h1;
	localparam logic [2:0] MODE_SLEEP    = 3'h3;
	localparam logic [2:0] MODE_RESTART  = 3'h4;
	localparam logic [2:0] GSEL_PLAIN    = 3'h0;
	localparam logic [2:0] GSEL_REG_ERR  = 3'h1;
	localparam logic [2:0] GSEL_WD_ERR   = 3'h2;
	localparam logic [2:0] GSEL_LWU      = 3'h3;
	localparam logic [2:0] GSEL_WUP      = 3'h4;
	localparam logic [2:0] GSEL_RST_CNT  = 3'h5;
	localparam logic [2:0] GSEL_CAN_FLT  = 3'h6;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 40;
	localparam int RST_PULSE_MIN_NS  = 20000;
	localparam int WAKE_PULSE_MIN_NS = 1000;
	localparam int RST_LOW_SHORT_NS  = 100000;
	localparam int RST_LOW_LONG_NS   = 2000000;
	localparam int RST_PULSE_MIN_CYC  = (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_PULSE_MIN_CYC = (WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_LOW_SHORT_CYC  = (RST_LOW_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_LOW_LONG_CYC   = (RST_LOW_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} swf_reg_req_t;
	typedef struct packed {
		logic reg_err;
		logic wd_err;
		logic bus_wake_pattern;
		logic rst_cnt_exceeded;
		logic can_fault;
	} swf_irq_src_t;
endpackage

// ---- hdl/swf_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module swf_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge i_clk) begin
		meta_reg <= i_async;
		o_sync   <= meta_reg;
	end
endmodule
`default_nettype wire

// ---- hdl/swf_wake_det.sv ----
// edge, pulse and cyclic-sense wake detector for one local wake input
`timescale 1ns/1ps
`default_nettype none
module swf_wake_det #(
	parameter int unsigned PULSE_MIN = 25
) (
	input  wire logic       i_clk,
	input  wire logic       i_bidir_reset_pin_n,
	input  wire logic       i_level,
	input  wire logic       i_en,
	input  wire logic [1:0] i_mode,
	input  wire logic       i_cyclic,
	input  wire logic       i_sample,
	output logic            o_event
);
	import swf_pkg::*;
	localparam int CW = $clog2(PULSE_MIN + 1);
	localparam logic [CW-1:0] CMAX = CW'(PULSE_MIN);
	logic          prev_reg, prev_next, stored_reg, stored_next;
	logic          inpulse_reg, inpulse_next, evt_next;
	logic [CW-1:0] cnt_reg, cnt_next;
	logic          rise, fall;

	always_comb begin
		rise         = i_level & ~prev_reg;
		fall         = ~i_level & prev_reg;
		prev_next    = i_level;
		stored_next  = stored_reg;
		inpulse_next = inpulse_reg;
		evt_next     = 1'b0;
		cnt_next     = (cnt_reg == CMAX) ? cnt_reg : cnt_reg + 1'b1;
		if (rise | fall) begin
			cnt_next     = '0;
			inpulse_next = ~inpulse_reg;
		end
		if (i_cyclic) begin
			// compare the fresh sample against the one stored last time
			if (i_sample) begin
				evt_next    = i_en & (i_level != stored_reg);
				stored_next = i_level;
			end
		end else begin
			stored_next = i_level;
			if (i_en) begin
				case (i_mode)
					WMODE_RISE:  evt_next = rise;
					WMODE_FALL:  evt_next = fall;
					WMODE_PULSE: evt_next = (rise | fall) & inpulse_reg & (cnt_reg == CMAX);
					default:     evt_next = rise | fall;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_bidir_reset_pin_n) begin
			prev_reg    <= i_level; // no false edge after reset from an idle-high pin
			stored_reg  <= 1'b0;
			inpulse_reg <= 1'b0;
			cnt_reg     <= '0;
			o_event     <= 1'b0;
		end else begin
			prev_reg    <= prev_next;
			stored_reg  <= stored_next;
			inpulse_reg <= inpulse_next;
			cnt_reg     <= cnt_next;
			o_event     <= evt_next;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_bidir_reset_pin_n);
	a_wake_rise_only: assert property (
		(i_en && !i_cyclic && i_mode == WMODE_RISE && fall) |=> !o_event)
		else $error("falling edge woke a rise-only input");
	a_wake_cyclic_cmp: assert property (
		(i_en && i_cyclic && i_sample && i_level != stored_reg) |=> o_event)
		else $error("cyclic sample change gave no wake");
endmodule
`default_nettype wire

// ---- hdl/swf_pin_ctrl.sv ----
// wake, fail-safe indicator, reset pin and flag output control of the chip
//
// Functional notes
// - CAN transceiver stays off in every chip mode except normal.
// - LIN transceiver has own register, works only in normal, may follow mode.
// - each wake input selects rising, falling or pulse wake.
// - after reset all three wake inputs enabled on either edge.
// - four wake registers hold level, status, selection and special features.
// - cyclic sensing compares each sample with stored state and wakes on change.
// - with direct drive the third wake input turns the high side switch on.
// - flag output follows a software bit by default.
// - flag output can instead show one selected interrupt source.
// - active hold pin blocks watchdog actions while the timer runs on.
// - hold pin polarity programmable to low through its setup register.
// - in sleep the hold pin can wake the chip.
// - fallback indicator is open-drain low, asserted after watchdog reset.
// - fallback indicator released only once error counter reaches zero.
// - when programmed, each fail-safe entry asserts the fallback indicator.
// - readback enable bit makes the indicator state visible in next bit.
// - long low pulse on reset pin enters restart and restores defaults.
// - restart mode drives reset pin low for entry-dependent time.
// - reset pin is open-drain bidirectional, configured by flag register.
// - interrupt output goes low while chip raises an interrupt.
`timescale 1ns/1ps
`default_nettype none
module swf_pin_ctrl #(
	parameter int unsigned RST_PULSE_MIN  = swf_pkg::RST_PULSE_MIN_CYC,
	parameter int unsigned WAKE_PULSE_MIN = swf_pkg::WAKE_PULSE_MIN_CYC,
	parameter int unsigned RST_LOW_SHORT  = swf_pkg::RST_LOW_SHORT_CYC,
	parameter int unsigned RST_LOW_LONG   = swf_pkg::RST_LOW_LONG_CYC
) (
	input  wire logic                 I_REF_CLK,
	input  wire logic                 I_BIDIR_RESET_PIN_N,
	input  wire swf_pkg::swf_reg_req_t I_REG_REQ,
	output logic [7:0]                O_REG_RDATA,
	output logic                      O_REG_RVALID,
	input  wire logic [2:0]           I_CHIP_MODE,
	input  wire logic                 I_PRIMARY_REG_OK,
	input  wire swf_pkg::swf_irq_src_t I_IRQ_SRC,
	input  wire logic                 I_IRQ_PENDING,
	input  wire logic                 I_WD_EXPIRE,
	input  wire logic                 I_WD_TIMEOUT_RESET,
	input  wire logic                 I_WD_GOOD_TRIGGER,
	input  wire logic                 I_WD_ERR_CNT_ZERO,
	input  wire logic                 I_FAILSAFE_ENTRY,
	input  wire logic                 I_CYCLIC_SAMPLE,
	input  wire logic [2:0]           I_LOCAL_WAKE_INPUTS,
	input  wire logic                 I_DEBUG_HOLD_PIN,
	input  wire logic                 I_BIDIR_RESET_PIN_N_I,
	output logic                      O_BIDIR_RESET_PIN_N_O,
	output logic                      O_BIDIR_RESET_PIN_N_OE,
	output logic                      O_LIMP_N_O,
	output logic                      O_LIMP_N_OE,
	output logic                      O_GENERAL_FLAG_OUTPUT,
	output logic                      O_INTERRUPT_OUT_N,
	output logic                      O_CAN_XCVR_ON,
	output logic                      O_LIN_XCVR_ON,
	output logic                      O_HSS_DIRECT_ON,
	output logic                      O_WAKE_REQ,
	output logic                      O_RESTART_REQ,
	output logic                      O_WD_ACTION
);
	import swf_pkg::*;
	localparam int CNTW = $clog2(RST_LOW_LONG + 1);

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WATCH = 3'b010,
		ST_DRIVE = 3'b100
	} swf_rst_state_t;

	// ----------------------------------------------------------------
	// pin synchronisers and wake detectors
	// ----------------------------------------------------------------
	logic [2:0] wake_lvl;
	logic       hold_lvl, rst_lvl;
	logic [2:0] wake_evt;
	swf_sync #(.W(5)) u_sync (
		.i_clk   (I_REF_CLK),
		.i_async ({I_LOCAL_WAKE_INPUTS, I_DEBUG_HOLD_PIN, I_BIDIR_RESET_PIN_N_I}),
		.o_sync  ({wake_lvl, hold_lvl, rst_lvl})
	);

	logic [7:0] supply_reg, supply_next, hold_reg, hold_next, can_reg, can_next;
	logic [7:0] devcfg_reg, devcfg_next, lin_reg, lin_next, flag_reg, flag_next;
	logic [7:0] local_wake_in_c_reg, local_wake_in_c_next, wake4_reg, wake4_next, rate_reg, rate_next;
	logic [2:0] wake_en_reg, wake_en_next, wake_st_reg, wake_st_next;
	logic [7:0] rdata_next;
	logic       rvalid_next;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_wake
			swf_wake_det #(.PULSE_MIN(WAKE_PULSE_MIN)) u_det (
				.i_clk    (I_REF_CLK),
				.i_bidir_reset_pin_n   (I_BIDIR_RESET_PIN_N),
				.i_level  (wake_lvl[gi]),
				.i_en     (wake_en_reg[gi]),
				.i_mode   (local_wake_in_c_reg[2*gi+:2]),
				.i_cyclic (wake4_reg[CYCLIC_BIT]),
				.i_sample (I_CYCLIC_SAMPLE),
				.o_event  (wake_evt[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// reset pin monitor and restart drive
	// ----------------------------------------------------------------
	swf_rst_state_t st_reg, st_next;
	logic [CNTW-1:0] cnt_reg, cnt_next;
	logic rst_prev_reg, rst_prev_next, inrst_prev_reg, inrst_prev_next;
	logic bypin_reg, bypin_next, rreq_next, rdrv_next;
	logic in_restart;

	always_comb begin
		in_restart      = (I_CHIP_MODE == MODE_RESTART);
		st_next         = st_reg;
		cnt_next        = cnt_reg;
		rst_prev_next   = rst_lvl;
		inrst_prev_next = (st_reg == ST_WATCH) ? inrst_prev_reg : in_restart;
		bypin_next      = bypin_reg;
		rreq_next       = 1'b0;
		rdrv_next       = 1'b0;
		case (st_reg)
			ST_IDLE: begin
				if (in_restart && !inrst_prev_reg) begin
					// low time depends on entry path and regulator state
					st_next    = ST_DRIVE;
					cnt_next   = (bypin_reg && I_PRIMARY_REG_OK) ?
						CNTW'(RST_LOW_SHORT) : CNTW'(RST_LOW_LONG);
					bypin_next = 1'b0;
					rdrv_next  = 1'b1;
				end else if (!in_restart && I_PRIMARY_REG_OK && flag_reg[FLAG_RSTMON_BIT]
					&& rst_prev_reg && !rst_lvl) begin
					st_next  = ST_WATCH;
					cnt_next = '0;
				end
			end
			ST_WATCH: begin
				if (rst_lvl || in_restart || !I_PRIMARY_REG_OK) begin
					st_next = ST_IDLE;
				end else if (cnt_reg == CNTW'(RST_PULSE_MIN - 1)) begin
					// width is a parameter, nothing fixes it
					st_next    = ST_IDLE;
					rreq_next  = 1'b1;
					bypin_next = 1'b1;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			ST_DRIVE: begin
				if (cnt_reg <= CNTW'(1)) begin
					st_next = ST_IDLE;
				end else begin
					cnt_next  = cnt_reg - 1'b1;
					rdrv_next = 1'b1;
				end
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_BIDIR_RESET_PIN_N) begin
			st_reg                 <= ST_IDLE;
			cnt_reg                <= '0;
			rst_prev_reg           <= 1'b1;
			inrst_prev_reg         <= 1'b0;
			bypin_reg              <= 1'b0;
			O_RESTART_REQ          <= 1'b0;
			O_BIDIR_RESET_PIN_N_OE <= 1'b0;
		end else begin
			st_reg                 <= st_next;
			cnt_reg                <= cnt_next;
			rst_prev_reg           <= rst_prev_next;
			inrst_prev_reg         <= inrst_prev_next;
			bypin_reg              <= bypin_next;
			O_RESTART_REQ          <= rreq_next;
			O_BIDIR_RESET_PIN_N_OE <= rdrv_next;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_comb begin
		supply_next  = supply_reg;
		hold_next    = hold_reg;
		can_next     = can_reg;
		devcfg_next  = devcfg_reg;
		lin_next     = lin_reg;
		flag_next    = flag_reg;
		local_wake_in_c_next   = local_wake_in_c_reg;
		wake4_next   = wake4_reg;
		rate_next    = rate_reg;
		wake_en_next = wake_en_reg;
		wake_st_next = wake_st_reg;
		rvalid_next  = I_REG_REQ.rd;
		rdata_next   = 8'h00;
		if (I_REG_REQ.wr) begin
			if (I_REG_REQ.addr == ADDR_SUPPLY) supply_next = I_REG_REQ.wdata;
			else if (I_REG_REQ.addr == ADDR_HOLD) hold_next = I_REG_REQ.wdata;
			else if (I_REG_REQ.addr == ADDR_CAN) can_next = I_REG_REQ.wdata;
			else if (I_REG_REQ.addr == ADDR_LOCAL_WAKE_IN_A) wake_en_next = I_REG_REQ.wdata[2:0];
			else if (I_REG_REQ.addr == ADDR_LOCAL_WAKE_IN_B) wake_st_next = wake_st_reg & ~I_REG_REQ.wdata[2:0];
			else if (I_REG_REQ.addr == ADDR_DEVCFG) devcfg_next = I_REG_REQ.wdata & 8'h41;
			else if (I_REG_REQ.addr == ADDR_LIN) lin_next = I_REG_REQ.wdata;
			else if (I_REG_REQ.addr == ADDR_FLAG) flag_next = I_REG_REQ.wdata;
			else if (I_REG_REQ.addr == ADDR_LOCAL_WAKE_IN_C) local_wake_in_c_next = I_REG_REQ.wdata;
			else if (I_REG_REQ.addr == ADDR_WAKE4) wake4_next = I_REG_REQ.wdata;
			else if (I_REG_REQ.addr == ADDR_RATE) rate_next = I_REG_REQ.wdata;
		end
		// a wake in the same cycle as its clear stays recorded
		wake_st_next = wake_st_next | wake_evt;
		if (O_RESTART_REQ) begin
			// restart restores the default configuration
			supply_next  = RST_SUPPLY;
			hold_next    = RST_HOLD;
			can_next     = RST_CAN;
			devcfg_next  = RST_DEVCFG;
			lin_next     = RST_LIN;
			flag_next    = RST_FLAG;
			local_wake_in_c_next   = RST_LOCAL_WAKE_IN_C;
			wake4_next   = RST_WAKE4;
			rate_next    = RST_RATE;
			wake_en_next = RST_WAKEEN;
		end
		if (I_REG_REQ.addr == ADDR_SUPPLY) rdata_next = supply_reg;
		else if (I_REG_REQ.addr == ADDR_HOLD) rdata_next = hold_reg;
		else if (I_REG_REQ.addr == ADDR_CAN) rdata_next = can_reg;
		else if (I_REG_REQ.addr == ADDR_LOCAL_WAKE_IN_A) rdata_next = {1'b0, wake_lvl, 1'b0, wake_en_reg};
		else if (I_REG_REQ.addr == ADDR_LOCAL_WAKE_IN_B) rdata_next = {5'h00, wake_st_reg};
		else if (I_REG_REQ.addr == ADDR_DEVCFG) begin
			rdata_next = devcfg_reg;
			rdata_next[LIMP_STATE_BIT] = devcfg_reg[LIMP_RD_EN_BIT] & O_LIMP_N_OE;
		end
		else if (I_REG_REQ.addr == ADDR_LIN) rdata_next = lin_reg;
		else if (I_REG_REQ.addr == ADDR_FLAG) rdata_next = flag_reg;
		else if (I_REG_REQ.addr == ADDR_LOCAL_WAKE_IN_C) rdata_next = local_wake_in_c_reg;
		else if (I_REG_REQ.addr == ADDR_WAKE4) rdata_next = wake4_reg;
		else if (I_REG_REQ.addr == ADDR_RATE) rdata_next = rate_reg;
		if (!I_REG_REQ.rd) rdata_next = 8'h00;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_BIDIR_RESET_PIN_N) begin
			supply_reg   <= RST_SUPPLY;
			hold_reg     <= RST_HOLD;
			can_reg      <= RST_CAN;
			devcfg_reg   <= RST_DEVCFG;
			lin_reg      <= RST_LIN;
			flag_reg     <= RST_FLAG;
			local_wake_in_c_reg    <= RST_LOCAL_WAKE_IN_C;
			wake4_reg    <= RST_WAKE4;
			rate_reg     <= RST_RATE;
			wake_en_reg  <= RST_WAKEEN;
			wake_st_reg  <= 3'h0;
			O_REG_RDATA  <= 8'h00;
			O_REG_RVALID <= 1'b0;
		end else begin
			supply_reg   <= supply_next;
			hold_reg     <= hold_next;
			can_reg      <= can_next;
			devcfg_reg   <= devcfg_next;
			lin_reg      <= lin_next;
			flag_reg     <= flag_next;
			local_wake_in_c_reg    <= local_wake_in_c_next;
			wake4_reg    <= wake4_next;
			rate_reg     <= rate_next;
			wake_en_reg  <= wake_en_next;
			wake_st_reg  <= wake_st_next;
			O_REG_RDATA  <= rdata_next;
			O_REG_RVALID <= rvalid_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs: transceivers, flag, hold, fallback, interrupt
	// ----------------------------------------------------------------
	logic hold_act, hold_prev_reg, limp_next, gfo_next, wake_next;
	logic is_normal;
	always_comb begin
		is_normal = (I_CHIP_MODE == MODE_NORMAL);
		hold_act  = (hold_lvl == hold_reg[HOLD_POL_BIT]);
		limp_next = O_LIMP_N_OE;
		if (I_WD_GOOD_TRIGGER && I_WD_ERR_CNT_ZERO) limp_next = 1'b0;
		// set wins over release
		if (I_WD_TIMEOUT_RESET) limp_next = 1'b1;
		if (I_FAILSAFE_ENTRY && devcfg_reg[LIMP_FS_BIT]) limp_next = 1'b1;
		case (flag_reg[2:0])
			GSEL_REG_ERR: gfo_next = I_IRQ_SRC.reg_err;
			GSEL_WD_ERR:  gfo_next = I_IRQ_SRC.wd_err;
			GSEL_LWU:     gfo_next = |wake_st_reg;
			GSEL_WUP:     gfo_next = I_IRQ_SRC.bus_wake_pattern;
			GSEL_RST_CNT: gfo_next = I_IRQ_SRC.rst_cnt_exceeded;
			GSEL_CAN_FLT: gfo_next = I_IRQ_SRC.can_fault;
			default:      gfo_next = flag_reg[FLAG_LEVEL_BIT];
		endcase
		// hold pin becoming active in sleep is a digital wake
		wake_next = (!is_normal && |wake_evt) || (I_CHIP_MODE == MODE_SLEEP
			&& hold_reg[HOLD_WAKE_BIT] && hold_act && !hold_prev_reg);
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_BIDIR_RESET_PIN_N) begin
			hold_prev_reg         <= 1'b1;
			O_CAN_XCVR_ON         <= 1'b0;
			O_LIN_XCVR_ON         <= 1'b0;
			O_HSS_DIRECT_ON       <= 1'b0;
			O_GENERAL_FLAG_OUTPUT <= 1'b0;
			O_WD_ACTION           <= 1'b0;
			O_LIMP_N_OE           <= 1'b0;
			O_LIMP_N_O            <= 1'b0;
			O_BIDIR_RESET_PIN_N_O <= 1'b0;
			O_INTERRUPT_OUT_N     <= 1'b1;
			O_WAKE_REQ            <= 1'b0;
		end else begin
			hold_prev_reg         <= hold_act;
			O_CAN_XCVR_ON         <= is_normal && |can_reg[XCVR_FOLLOW_BIT:XCVR_EN_BIT];
			O_LIN_XCVR_ON         <= is_normal && |lin_reg[XCVR_FOLLOW_BIT:XCVR_EN_BIT];
			O_HSS_DIRECT_ON       <= wake4_reg[DIRECT_BIT] & wake_lvl[2];
			O_GENERAL_FLAG_OUTPUT <= gfo_next;
			O_WD_ACTION           <= I_WD_EXPIRE & ~hold_act;
			O_LIMP_N_OE           <= limp_next;
			O_LIMP_N_O            <= 1'b0;
			O_BIDIR_RESET_PIN_N_O <= 1'b0;
			O_INTERRUPT_OUT_N     <= ~(I_IRQ_PENDING | (|wake_st_reg));
			O_WAKE_REQ            <= wake_next;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_BIDIR_RESET_PIN_N);
	sequence s_low_held;
		(st_reg == ST_WATCH && !rst_lvl)[*2];
	endsequence
	a_can_off_mode: assert property (!is_normal |=> !O_CAN_XCVR_ON)
		else $error("CAN on outside normal mode");
	a_lin_off_mode: assert property (!is_normal |=> !O_LIN_XCVR_ON)
		else $error("LIN on outside normal mode");
	a_hold_blocks_wd: assert property ((I_WD_EXPIRE && hold_act) |=> !O_WD_ACTION)
		else $error("watchdog action while hold active");
	a_limp_set: assert property (I_WD_TIMEOUT_RESET |=> O_LIMP_N_OE)
		else $error("fallback not asserted after watchdog reset");
	a_limp_release: assert property (
		$fell(O_LIMP_N_OE) |-> $past(I_WD_GOOD_TRIGGER && I_WD_ERR_CNT_ZERO))
		else $error("fallback released without zero error count");
	a_gfo_plain: assert property (
		(flag_reg[2:0] == GSEL_PLAIN) |=> O_GENERAL_FLAG_OUTPUT == $past(flag_reg[FLAG_LEVEL_BIT]))
		else $error("flag output does not follow its bit");
	a_restart_req: assert property ($rose(O_RESTART_REQ) |-> $past(st_reg == ST_WATCH))
		else $error("restart without a watched low pulse");
	a_watch_hold: assert property (s_low_held |-> !O_BIDIR_RESET_PIN_N_OE)
		else $error("pin driven while being watched");
	a_rst_drive: assert property (
		(st_reg == ST_IDLE && in_restart && !inrst_prev_reg) |=> O_BIDIR_RESET_PIN_N_OE [*2])
		else $error("reset pin not driven in restart");
	a_int_low: assert property (I_IRQ_PENDING |=> !O_INTERRUPT_OUT_N)
		else $error("interrupt output not low");
	a_hss_direct: assert property (
		(wake4_reg[DIRECT_BIT] && wake_lvl[2]) |=> O_HSS_DIRECT_ON)
		else $error("direct drive switch not on");
endmodule
`default_nettype wire

// ---- verif/swf_host.sv ----
// host model driving the decoded register port one request at a time
`timescale 1ns/1ps
`default_nettype none
module swf_host (
	input  wire logic                 i_clk,
	input  wire logic [7:0]           i_rdata,
	output var swf_pkg::swf_reg_req_t o_req
);
	initial o_req = '0;
	task automatic xfer(input logic [7:0] a, d, input logic w, output logic [7:0] q);
		@(negedge i_clk) o_req = '{a, d, w, !w};
		@(negedge i_clk) q = i_rdata;
		o_req = '0;
	endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import swf_pkg::*;
	logic         clk = 0, bidir_reset_pin_n = 0, rdrv = 1, czero = 0, hold = 1;
	logic [2:0]   mode = 0, wk = 0, stb = 0;
	logic [7:0]   rdata, fv, q;
	logic         roe, loe, flag, int_n, can, lin, wreq, rreq, wda;
	logic         ipend = 0, fse = 0, csmp = 0, rvalid, high_side_switch;
	swf_irq_src_t irq = '0;
	swf_reg_req_t req;
	int           checks = 0, bad_count = 0, cycles = 0, seed = 32'hF84A;
	wire logic    rpin = roe ? 1'b0 : rdrv;
	wire logic [4:0] pl = {loe, roe, wda, rreq, wreq};
	always #20 clk = ~clk;
	always @(posedge clk) if (++cycles == 5000) finish_test;
	swf_host host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
	swf_pin_ctrl #(.RST_PULSE_MIN(4), .WAKE_PULSE_MIN(3), .RST_LOW_SHORT(5),
		.RST_LOW_LONG(10)) dut (.I_REF_CLK(clk), .I_BIDIR_RESET_PIN_N(bidir_reset_pin_n), .I_REG_REQ(req),
		.O_REG_RDATA(rdata), .O_REG_RVALID(rvalid), .I_CHIP_MODE(mode),
		.I_PRIMARY_REG_OK(1'b1), .I_IRQ_SRC(irq), .I_IRQ_PENDING(ipend),
		.I_WD_EXPIRE(stb[0]), .I_WD_TIMEOUT_RESET(stb[1]),
		.I_WD_GOOD_TRIGGER(stb[2]), .I_WD_ERR_CNT_ZERO(czero), .I_FAILSAFE_ENTRY(fse),
		.I_CYCLIC_SAMPLE(csmp), .I_LOCAL_WAKE_INPUTS(wk), .I_DEBUG_HOLD_PIN(hold),
		.I_BIDIR_RESET_PIN_N_I(rpin), .O_BIDIR_RESET_PIN_N_O(), .O_BIDIR_RESET_PIN_N_OE(roe),
		.O_LIMP_N_O(), .O_LIMP_N_OE(loe), .O_GENERAL_FLAG_OUTPUT(flag), .O_INTERRUPT_OUT_N(int_n),
		.O_CAN_XCVR_ON(can), .O_LIN_XCVR_ON(lin), .O_HSS_DIRECT_ON(high_side_switch), .O_WAKE_REQ(wreq),
		.O_RESTART_REQ(rreq), .O_WD_ACTION(wda));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		bad_count += (got !== exp);
		if (got !== exp) $display("ERROR %0t got %h exp %h", $time, got, exp);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host.xfer(a, 8'h00, 1'b0, q);
		chk(q, e);
		chk(rvalid, 1'b1);
	endtask
	task automatic cnt(input int i, input logic [7:0] e, input logic [2:0] p);
		logic [7:0] n = 8'h00;
		@(negedge clk) n = {7'h00, pl[i]};
		stb = p;
		repeat (20) @(negedge clk) begin
			n += pl[i];
			stb = 3'h0;
		end
		chk(n, e);
	endtask
	task automatic finish_test;
		if (cycles >= 5000) bad_count++;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		bidir_reset_pin_n = 1'b1;
		rd(ADDR_LOCAL_WAKE_IN_A, {5'h00, RST_WAKEEN});
		host.xfer(ADDR_CAN, 8'h02, 1'b1, q);
		host.xfer(ADDR_LIN, 8'h01, 1'b1, q);
		for (int m = 0; m < 8; m++) begin
			// restart code skipped: its drive would pull the reset pin low mid-loop
			mode = (m == 4) ? MODE_SLEEP : m[2:0];
			irq = 5'($random(seed));
			host.xfer(ADDR_FLAG, {5'h06, m[2:0]}, 1'b1, q);
			fv = {1'b1, irq[0], irq[1], irq[2], 1'b0, irq[3], irq[4], 1'b1};
			repeat (2) @(negedge clk);
			chk({can, lin, flag}, {m == 1, m == 1, fv[m]});
		end
		mode = MODE_SLEEP;
		host.xfer(ADDR_LOCAL_WAKE_IN_C, {4'h0, WMODE_FALL, WMODE_RISE}, 1'b1, q);
		wk = 3'b011;
		cnt(0, 8'h01, 3'h0);
		chk(int_n, 1'b0);
		rd(ADDR_LOCAL_WAKE_IN_B, 8'h01);
		host.xfer(ADDR_WAKE4, 8'h03, 1'b1, q);
		wk = 3'b111;
		repeat (4) @(negedge clk);
		rd(ADDR_LOCAL_WAKE_IN_B, 8'h01);
		chk(high_side_switch, 1'b1);
		csmp = 1'b1;
		@(negedge clk) csmp = 1'b0;
		rd(ADDR_LOCAL_WAKE_IN_B, 8'h05);
		host.xfer(ADDR_LOCAL_WAKE_IN_B, 8'h07, 1'b1, q);
		repeat (2) @(negedge clk);
		chk(int_n, 1'b1);
		ipend = 1'b1;
		repeat (2) @(negedge clk);
		chk(int_n, 1'b0);
		ipend = 1'b0;
		cnt(2, 8'h00, 3'h1);
		host.xfer(ADDR_HOLD, 8'h00, 1'b1, q);
		cnt(2, 8'h01, 3'h1);
		host.xfer(ADDR_HOLD, 8'h02, 1'b1, q);
		hold = 1'b0;
		cnt(0, 8'h01, 3'h0);
		cnt(4, 8'h14, 3'h2);
		host.xfer(ADDR_DEVCFG, 8'h40, 1'b1, q);
		rd(ADDR_DEVCFG, 8'h60);
		czero = 1'b1;
		cnt(4, 8'h01, 3'h4);
		chk(loe, 1'b0);
		fse = 1'b1;
		@(negedge clk) fse = 1'b0;
		chk(loe, 1'b0);
		host.xfer(ADDR_DEVCFG, 8'h41, 1'b1, q);
		fse = 1'b1;
		@(negedge clk) fse = 1'b0;
		chk(loe, 1'b1);
		rdrv = 1'b0;
		cnt(1, 8'h01, 3'h0);
		rdrv = 1'b1;
		rd(ADDR_HOLD, RST_HOLD);
		mode = MODE_RESTART;
		cnt(3, 8'h05, 3'h0);
		finish_test;
	end
endmodule
`default_nettype wire
